//--- dfl_ctl.sv
// Controller end: issues network side and local host port register accesses.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module dfl_ctl
  import dfl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  dfl_if.ctl               bus,
  input  wire logic [4:0]  usr_addr,
  input  wire logic [31:0] usr_wdata,
  input  wire logic        usr_wr,
  input  wire logic        usr_rd,
  output logic      [31:0] usr_rdata
);

  // ==========================================================================
  // Command registers
  dfl_state_t  st_r;
  dfl_state_t  st_nxt;
  logic [31:0] acc_r;
  logic        legacy_r;
  logic [15:0] start_r;
  logic [7:0]  last_rd_r;
  logic [7:0]  last_rd_nxt;
  logic        op_rd_r;
  logic        op_rd_nxt;
  logic        wr_r;
  logic        wr_nxt;
  logic        rd_r;
  logic        rd_nxt;
  logic        side_r;
  logic        side_nxt;
  logic [11:0] addr_r;
  logic [11:0] addr_nxt;
  logic [7:0]  wdata_r;
  logic [7:0]  wdata_nxt;

  wire         sel_acc  = usr_wr && (usr_addr == DFL_CR_ACCESS);
  wire         sel_go   = usr_wr && (usr_addr == DFL_CR_GO);
  wire         sel_cfg  = usr_wr && (usr_addr == DFL_CR_CFG);
  wire         busy     = (st_r != DFL_IDLE);
  wire         go_wr    = sel_go && usr_wdata[DFL_GO_WR_BIT];
  wire         go_rd    = sel_go && usr_wdata[DFL_GO_RD_BIT];
  wire         is_depth = (addr_r == DFL_ADR_TDIFF_DEPTH) ||
                          (addr_r == DFL_ADR_SPEED_DEPTH);
  wire [7:0]   rd_in    = side_r ? bus.host_rdata : bus.net_rdata;
  wire [31:0]  status_w = {16'h0000, last_rd_r, 7'h00, busy};

  // ==========================================================================
  // Access sequencer
  always_comb
  begin
    st_nxt      = st_r;
    wr_nxt      = 1'b0;
    rd_nxt      = 1'b0;
    side_nxt    = side_r;
    addr_nxt    = addr_r;
    wdata_nxt   = wdata_r;
    op_rd_nxt   = op_rd_r;
    last_rd_nxt = last_rd_r;
    case (st_r)
      DFL_IDLE:
      begin
        if (go_wr || go_rd)
        begin
          st_nxt    = DFL_ISSUE;
          wr_nxt    = !go_rd;
          rd_nxt    = go_rd;
          op_rd_nxt = go_rd;
          side_nxt  = acc_r[DFL_ACC_SIDE_BIT];
          addr_nxt  = acc_r[11:0];
          wdata_nxt = acc_r[DFL_ACC_DATA_LSB +: 8];
        end
      end
      DFL_ISSUE:
      begin
        if (op_rd_r)
          st_nxt = DFL_CAPT;
        else if (legacy_r && is_depth)
        begin
          st_nxt    = DFL_FOL_LO;
          wr_nxt    = 1'b1;
          addr_nxt  = DFL_ADR_SPD_START_L;
          wdata_nxt = start_r[7:0];
        end
        else
          st_nxt = DFL_IDLE;
      end
      DFL_CAPT:
      begin
        last_rd_nxt = rd_in;
        st_nxt      = DFL_IDLE;
      end
      DFL_FOL_LO:
      begin
        st_nxt    = DFL_FOL_HI;
        wr_nxt    = 1'b1;
        addr_nxt  = DFL_ADR_SPD_START_H;
        wdata_nxt = start_r[15:8];
      end
      DFL_FOL_HI:
        st_nxt = DFL_IDLE;
      default:
        st_nxt = DFL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r      <= DFL_IDLE;
      wr_r      <= 1'b0;
      rd_r      <= 1'b0;
      side_r    <= 1'b0;
      addr_r    <= 12'h000;
      wdata_r   <= 8'h00;
      op_rd_r   <= 1'b0;
      last_rd_r <= 8'h00;
    end
    else
    begin
      st_r      <= st_nxt;
      wr_r      <= wr_nxt;
      rd_r      <= rd_nxt;
      side_r    <= side_nxt;
      addr_r    <= addr_nxt;
      wdata_r   <= wdata_nxt;
      op_rd_r   <= op_rd_nxt;
      last_rd_r <= last_rd_nxt;
    end
  end

  // ==========================================================================
  // Software port
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_r     <= 32'h00000000;
      legacy_r  <= DFL_LEGACY_RST;
      start_r   <= DFL_START_RST;
      usr_rdata <= 32'h00000000;
    end
    else
    begin
      if (sel_acc)
        acc_r <= usr_wdata;
      if (sel_cfg)
      begin
        legacy_r <= usr_wdata[DFL_CFG_LEGACY_BIT];
        start_r  <= usr_wdata[DFL_CFG_START_LSB +: 16];
      end
      if (!usr_rd)
        usr_rdata <= 32'h00000000;
      else if (usr_addr == DFL_CR_ACCESS)
        usr_rdata <= acc_r;
      else if (usr_addr == DFL_CR_CFG)
        usr_rdata <= {start_r, 15'h0000, legacy_r};
      else if (usr_addr == DFL_CR_STATUS)
        usr_rdata <= status_w;
      else
        usr_rdata <= 32'h00000000;
    end
  end

  assign bus.net_wr     = wr_r && !side_r;
  assign bus.net_rd     = rd_r && !side_r;
  assign bus.host_wr    = wr_r && side_r;
  assign bus.host_rd    = rd_r && side_r;
  assign bus.net_addr   = addr_r;
  assign bus.host_addr  = addr_r;
  assign bus.net_wdata  = wdata_r;
  assign bus.host_wdata = wdata_r;

endmodule : dfl_ctl
`default_nettype wire

//--- dfl_pkg.sv
// Shared constants and types of the clock-filter and latch-control block.
`default_nettype none
package dfl_pkg;

  // ==========================================================================
  // Device register offsets
  localparam logic [11:0] DFL_ADR_TIME_LATCH  = 12'h900;
  localparam logic [11:0] DFL_ADR_SPD_START_L = 12'h930;
  localparam logic [11:0] DFL_ADR_SPD_START_H = 12'h931;
  localparam logic [11:0] DFL_ADR_TDIFF_DEPTH = 12'h934;
  localparam logic [11:0] DFL_ADR_SPEED_DEPTH = 12'h935;
  localparam logic [11:0] DFL_ADR_LATCH_MODE  = 12'h936;
  localparam logic [11:0] DFL_ADR_CYC_OWNER   = 12'h980;

  // ==========================================================================
  // Device fields and reset values
  localparam int          DFL_DEPTH_W         = 4;
  localparam logic [3:0]  DFL_TDIFF_DEPTH_RST = 4'h4;
  localparam logic [3:0]  DFL_SPEED_DEPTH_RST = 4'hC;
  localparam logic        DFL_LATCH_MODE_RST  = 1'b0;
  localparam logic [2:0]  DFL_CYC_OWNER_RST   = 3'h0;
  localparam int          DFL_LMODE_BIT       = 0;
  localparam int          DFL_CYC_BIT         = 0;
  localparam int          DFL_LATCH0_BIT      = 4;
  localparam int          DFL_LATCH1_BIT      = 5;

  // ==========================================================================
  // Controller register offsets, fields and reset values
  localparam logic [4:0]  DFL_CR_ACCESS      = 5'h00;
  localparam logic [4:0]  DFL_CR_GO          = 5'h04;
  localparam logic [4:0]  DFL_CR_CFG         = 5'h08;
  localparam logic [4:0]  DFL_CR_STATUS      = 5'h0C;
  localparam int          DFL_ACC_SIDE_BIT   = 12;
  localparam int          DFL_ACC_DATA_LSB   = 16;
  localparam int          DFL_GO_WR_BIT      = 0;
  localparam int          DFL_GO_RD_BIT      = 1;
  localparam int          DFL_CFG_LEGACY_BIT = 0;
  localparam int          DFL_CFG_START_LSB  = 16;
  localparam logic [15:0] DFL_START_RST      = 16'h1000;
  localparam logic        DFL_LEGACY_RST     = 1'b0;

  typedef enum logic [2:0] {
    DFL_IDLE,
    DFL_ISSUE,
    DFL_CAPT,
    DFL_FOL_LO,
    DFL_FOL_HI
  } dfl_state_t;

endpackage : dfl_pkg
`default_nettype wire

//--- dfl_if.sv
// Register access lines between the controller end and the device end.
`timescale 1ns/10ps
`default_nettype none
interface dfl_if;
  logic        net_wr;
  logic        net_rd;
  logic [11:0] net_addr;
  logic [7:0]  net_wdata;
  logic [7:0]  net_rdata;
  logic        host_wr;
  logic        host_rd;
  logic [11:0] host_addr;
  logic [7:0]  host_wdata;
  logic [7:0]  host_rdata;

  modport dev (
    input  net_wr, net_rd, net_addr, net_wdata,
    input  host_wr, host_rd, host_addr, host_wdata,
    output net_rdata, host_rdata
  );

  modport ctl (
    output net_wr, net_rd, net_addr, net_wdata,
    output host_wr, host_rd, host_addr, host_wdata,
    input  net_rdata, host_rdata
  );
endinterface : dfl_if
`default_nettype wire

//--- dfl_dev.sv
// Device end: filter depth, latch mode and cyclic ownership registers.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Deviation computed by software after settling.
// - Local period is one minus deviation.
// - Difference depth four bits, resets to four.
// - Legacy: rewrite speed start after depth.
// - Speed depth four bits, resets to twelve.
// - Legacy: rewrite speed start after depth.
// - Depth writes only from time owner.
// - Forwarding mode arms stamps after latch write.
// - Reverse mode copies hidden stamps immediately.
// - Master keeps other frames off network.
// - Bit zero picks cyclic unit owner.
// - Bits four, five route latch units.
// - Host-owned time forces latch zero host.
module dfl_dev
  import dfl_pkg::*;
#(
  parameter bit NEWER_REV = 1'b1
)
(
  input  wire logic       clk,
  input  wire logic       nrst,
  dfl_if.dev              bus,
  input  wire logic       sys_time_host_ctrl,
  input  wire logic [1:0] latch_evt,
  output logic            tdiff_clear,
  output logic            speed_filt_clear,
  output logic            rx_stamp_arm,
  output logic            rx_stamp_copy,
  output logic [3:0]      tdiff_depth,
  output logic [3:0]      speed_depth,
  output logic            cyc_host_owned,
  output logic [1:0]      latch_host_owned,
  output logic [1:0]      net_latch_irq,
  output logic [1:0]      host_latch_irq
);

  // ==========================================================================
  // Read decoding
  function automatic logic [7:0] rd_sel(
    input logic [11:0] a,
    input logic [3:0]  td,
    input logic [3:0]  sd,
    input logic        lm,
    input logic        cy,
    input logic [1:0]  lo
  );
    logic [7:0] v;
    v = 8'h00;
    if (a == DFL_ADR_TDIFF_DEPTH)
      v = {4'h0, td};
    else if (a == DFL_ADR_SPEED_DEPTH)
      v = {4'h0, sd};
    else if (a == DFL_ADR_LATCH_MODE)
      v = {7'h00, lm};
    else if (a == DFL_ADR_CYC_OWNER)
      v = {2'b00, lo, 3'b000, cy};
    return v;
  endfunction : rd_sel

  // ==========================================================================
  // Input synchronisers
  // The ownership strap and latch inputs come from pins outside this domain.
  logic [1:0] own_sync_r;
  logic [1:0] latch_s1_r;
  logic [1:0] latch_s2_r;
  logic [1:0] latch_d_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      own_sync_r <= 2'b00;
      latch_s1_r <= 2'b00;
      latch_s2_r <= 2'b00;
      latch_d_r  <= 2'b00;
    end
    else
    begin
      own_sync_r <= {own_sync_r[0], sys_time_host_ctrl};
      latch_s1_r <= latch_evt;
      latch_s2_r <= latch_s1_r;
      latch_d_r  <= latch_s2_r;
    end
  end

  wire       st_host    = own_sync_r[1];
  wire [1:0] latch_rise = latch_s2_r & ~latch_d_r;

  // ==========================================================================
  // Write decoding
  logic [3:0] tdiff_depth_r;
  logic [3:0] speed_depth_r;
  logic       latch_mode_r;
  logic [2:0] cyc_own_r;

  wire       own_wr    = st_host ? bus.host_wr : bus.net_wr;
  wire [11:0] own_addr = st_host ? bus.host_addr : bus.net_addr;
  wire [7:0] own_wdata = st_host ? bus.host_wdata : bus.net_wdata;

  wire wr_tdiff = own_wr && (own_addr == DFL_ADR_TDIFF_DEPTH);
  wire wr_speed = own_wr && (own_addr == DFL_ADR_SPEED_DEPTH);
  wire wr_start = own_wr && ((own_addr == DFL_ADR_SPD_START_L) ||
                             (own_addr == DFL_ADR_SPD_START_H));

  wire wr_lmode = bus.net_wr && (bus.net_addr == DFL_ADR_LATCH_MODE);
  wire wr_cyc   = bus.net_wr && (bus.net_addr == DFL_ADR_CYC_OWNER);
  wire wr_latch = bus.net_wr && (bus.net_addr == DFL_ADR_TIME_LATCH);

  wire tdiff_clr_nxt = wr_start || (NEWER_REV && wr_tdiff);
  wire speed_clr_nxt = wr_start || (NEWER_REV && wr_speed);

  wire       cyc_host  = cyc_own_r[0];
  wire [1:0] latch_own = {cyc_own_r[2], cyc_own_r[1] || st_host};

  // ==========================================================================
  // Register file
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tdiff_depth_r <= DFL_TDIFF_DEPTH_RST;
      speed_depth_r <= DFL_SPEED_DEPTH_RST;
      latch_mode_r  <= DFL_LATCH_MODE_RST;
      cyc_own_r     <= DFL_CYC_OWNER_RST;
    end
    else
    begin
      if (wr_tdiff)
        tdiff_depth_r <= own_wdata[DFL_DEPTH_W-1:0];
      if (wr_speed)
        speed_depth_r <= own_wdata[DFL_DEPTH_W-1:0];
      if (wr_lmode)
        latch_mode_r <= bus.net_wdata[DFL_LMODE_BIT];
      if (wr_cyc)
        cyc_own_r <= {bus.net_wdata[DFL_LATCH1_BIT],
                      bus.net_wdata[DFL_LATCH0_BIT],
                      bus.net_wdata[DFL_CYC_BIT]};
    end
  end

  // ==========================================================================
  // Event pulses and read data
  // Read data stand for exactly one cycle, so stale values never linger.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tdiff_clear      <= 1'b0;
      speed_filt_clear <= 1'b0;
      rx_stamp_arm     <= 1'b0;
      rx_stamp_copy    <= 1'b0;
      net_latch_irq    <= 2'b00;
      host_latch_irq   <= 2'b00;
      bus.net_rdata    <= 8'h00;
      bus.host_rdata   <= 8'h00;
    end
    else
    begin
      tdiff_clear      <= tdiff_clr_nxt;
      speed_filt_clear <= speed_clr_nxt;
      rx_stamp_arm     <= wr_latch && !latch_mode_r;
      rx_stamp_copy    <= wr_latch && latch_mode_r;
      net_latch_irq    <= latch_rise & ~latch_own;
      host_latch_irq   <= latch_rise & latch_own;
      bus.net_rdata    <= bus.net_rd ?
        rd_sel(bus.net_addr, tdiff_depth_r, speed_depth_r,
               latch_mode_r, cyc_host, latch_own) : 8'h00;
      bus.host_rdata   <= bus.host_rd ?
        rd_sel(bus.host_addr, tdiff_depth_r, speed_depth_r,
               latch_mode_r, cyc_host, latch_own) : 8'h00;
    end
  end

  assign tdiff_depth      = tdiff_depth_r;
  assign speed_depth      = speed_depth_r;
  assign cyc_host_owned   = cyc_host;
  assign latch_host_owned = latch_own;

endmodule : dfl_dev
`default_nettype wire

//--- dfl_sva.sv
// Checker for the register lines and device outputs of the filter block.
`timescale 1ns/10ps
`default_nettype none
module dfl_sva
  import dfl_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        net_wr,
  input wire logic [11:0] net_addr,
  input wire logic [7:0]  net_wdata,
  input wire logic        host_wr,
  input wire logic [11:0] host_addr,
  input wire logic        sys_time_host_ctrl,
  input wire logic        tdiff_clear,
  input wire logic        speed_filt_clear,
  input wire logic        rx_stamp_arm,
  input wire logic        rx_stamp_copy,
  input wire logic [3:0]  tdiff_depth,
  input wire logic [3:0]  speed_depth,
  input wire logic        cyc_host_owned,
  input wire logic [1:0]  latch_host_owned,
  input wire logic [1:0]  net_latch_irq,
  input wire logic [1:0]  host_latch_irq
);
  // ==========================================================================
  // Helper state
  // The strap is trusted only after four steady samples, as the device
  // passes it through two flops first.
  logic [3:0] own_r;
  logic       lmode_r;
  wire        own_net  = (own_r == 4'h0);
  wire        own_host = &own_r;
  wire        n934     = net_wr && (net_addr == DFL_ADR_TDIFF_DEPTH);
  wire        n935     = net_wr && (net_addr == DFL_ADR_SPEED_DEPTH);
  wire        h934     = host_wr && (host_addr == DFL_ADR_TDIFF_DEPTH);
  wire        n900     = net_wr && (net_addr == DFL_ADR_TIME_LATCH);
  wire        n980     = net_wr && (net_addr == DFL_ADR_CYC_OWNER);
  wire        n930     = net_wr && (net_addr == DFL_ADR_SPD_START_L);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      own_r   <= 4'h0;
      lmode_r <= 1'h0;
    end
    else
    begin
      own_r <= {own_r[2:0], sys_time_host_ctrl};
      if (net_wr && (net_addr == DFL_ADR_LATCH_MODE))
        lmode_r <= net_wdata[0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Properties
  a_tdiff_write: assert property (n934 && own_net |=>
    tdiff_depth == $past(net_wdata[3:0]) && tdiff_clear)
    else $error("difference depth write not applied");
  a_speed_write: assert property (n935 && own_net |=>
    speed_depth == $past(net_wdata[3:0]) && speed_filt_clear)
    else $error("speed depth write not applied");
  a_depth_refused: assert property (!(n934 && !own_host) &&
    !(h934 && !own_net) |=> $stable(tdiff_depth))
    else $error("difference depth changed by non-owner");
  a_arm_forward: assert property (n900 && !lmode_r |=>
    rx_stamp_arm && !rx_stamp_copy)
    else $error("forwarding mode did not arm stamps");
  a_copy_reverse: assert property (n900 && lmode_r |=>
    rx_stamp_copy && !rx_stamp_arm)
    else $error("reverse mode did not copy stamps");
  a_cyc_owner: assert property (n980 |=>
    cyc_host_owned == $past(net_wdata[0]))
    else $error("cyclic owner bit not taken");
  a_host_ignored: assert property (host_wr && !net_wr |=>
    $stable(cyc_host_owned) && $stable(latch_host_owned[1]))
    else $error("host write changed ownership");
  a_latch_force: assert property (own_host |->
    latch_host_owned[0])
    else $error("latch zero not forced to host");
  // The pulse was routed by the owner of the cycle before it stands.
  a_irq_route: assert property ((net_latch_irq &
    $past(latch_host_owned)) == 2'h0 &&
    (host_latch_irq & ~$past(latch_host_owned)) == 2'h0)
    else $error("latch interrupt sent to wrong side");
  a_start_clear: assert property (n930 && own_net |=>
    tdiff_clear && speed_filt_clear)
    else $error("speed start write did not clear filters");

  c_arm: cover property (n900 && !lmode_r);
  c_copy: cover property (n900 && lmode_r);
  c_host_irq: cover property (host_latch_irq[0]);
  c_net_irq: cover property (net_latch_irq[1]);
  c_start: cover property (n930 && own_net);
endmodule : dfl_sva
`default_nettype wire

//--- dc_filter_latch_control_test.sv
// Self-checking bench joining the controller end to the device end.
`timescale 1ns/10ps
`default_nettype none
module dc_filter_latch_control_test;
  import dfl_pkg::*;
  typedef struct packed {
    logic        ws;
    logic [11:0] a;
    logic [7:0]  d;
    logic        rs;
    logic [7:0]  e;
  } dfl_row_t;

  // ==========================================================================
  // Write on one side, read back on a side; 0 is network, 1 is host.
  localparam dfl_row_t ROWS [12] = '{
    '{1'h0, 12'h934, 8'h07, 1'h1, 8'h07}, '{1'h0, 12'h934, 8'hFF, 1'h0, 8'h0F},
    '{1'h1, 12'h934, 8'h09, 1'h0, 8'h0F}, '{1'h0, 12'h935, 8'h03, 1'h1, 8'h03},
    '{1'h1, 12'h935, 8'h01, 1'h0, 8'h03}, '{1'h0, 12'h936, 8'hFF, 1'h1, 8'h01},
    '{1'h1, 12'h936, 8'h00, 1'h0, 8'h01}, '{1'h0, 12'h980, 8'hFF, 1'h1, 8'h31},
    '{1'h1, 12'h980, 8'h00, 1'h0, 8'h31}, '{1'h0, 12'h980, 8'h00, 1'h0, 8'h00},
    '{1'h0, 12'h936, 8'h00, 1'h0, 8'h00}, '{1'h0, 12'h123, 8'h5A, 1'h0, 8'h00}};

  logic        clk;
  logic        nrst;
  logic [4:0]  usr_addr;
  logic [31:0] usr_wdata;
  logic        usr_wr;
  logic        usr_rd;
  logic [31:0] usr_rdata;
  logic        strap;
  logic [1:0]  latch_evt;
  logic        tclr, sclr, arm, cpy, cyc;
  logic [3:0]  tdep, sdep;
  logic [1:0]  lown, nirq, hirq;
  int          num_errors = 0;
  int          n_checks = 0;
  int          arm_n = 0;
  int          cpy_n = 0;
  int          tclr_n = 0;
  int          sclr_n = 0;

  dfl_if u_dfl_if ();
  dfl_ctl u_dfl_ctl (.clk(clk), .nrst(nrst), .bus(u_dfl_if),
    .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_wr(usr_wr),
    .usr_rd(usr_rd), .usr_rdata(usr_rdata));
  dfl_dev u_dfl_dev (.clk(clk), .nrst(nrst), .bus(u_dfl_if),
    .sys_time_host_ctrl(strap), .latch_evt(latch_evt), .tdiff_clear(tclr),
    .speed_filt_clear(sclr), .rx_stamp_arm(arm), .rx_stamp_copy(cpy),
    .tdiff_depth(tdep), .speed_depth(sdep), .cyc_host_owned(cyc),
    .latch_host_owned(lown), .net_latch_irq(nirq), .host_latch_irq(hirq));
  dfl_sva u_dfl_sva (.clk(clk), .nrst(nrst), .net_wr(u_dfl_if.net_wr),
    .net_addr(u_dfl_if.net_addr), .net_wdata(u_dfl_if.net_wdata),
    .host_wr(u_dfl_if.host_wr), .host_addr(u_dfl_if.host_addr),
    .sys_time_host_ctrl(strap), .tdiff_clear(tclr), .speed_filt_clear(sclr),
    .rx_stamp_arm(arm), .rx_stamp_copy(cpy), .tdiff_depth(tdep),
    .speed_depth(sdep), .cyc_host_owned(cyc), .latch_host_owned(lown),
    .net_latch_irq(nirq), .host_latch_irq(hirq));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    arm_n += (arm === 1'h1);
    cpy_n += (cpy === 1'h1);
    tclr_n += (tclr === 1'h1);
    sclr_n += (sclr === 1'h1);
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic uwr(input logic [4:0] a, input logic [31:0] d);
    usr_addr  <= a;
    usr_wdata <= d;
    usr_wr    <= 1'h1;
    @(posedge clk);
    usr_wr <= 1'h0;
    @(posedge clk);
  endtask : uwr

  task automatic urd(input logic [4:0] a, output logic [31:0] d);
    usr_addr <= a;
    usr_rd   <= 1'h1;
    @(posedge clk);
    usr_rd <= 1'h0;
    #1;
    d = usr_rdata;
    @(posedge clk);
  endtask : urd

  // The controller serialises accesses, so each one waits for busy to drop.
  task automatic dacc(input logic s, input logic [11:0] a,
                      input logic [7:0] wd, input logic [1:0] go,
                      output logic [7:0] rd);
    logic [31:0] st;
    uwr(DFL_CR_ACCESS, {8'h00, wd, 3'h0, s, a});
    uwr(DFL_CR_GO, {30'h0, go});
    st = 32'h1;
    for (int n = 0; n < 20 && st[0] !== 1'h0; n++)
      urd(DFL_CR_STATUS, st);
    chk("busy", {7'h0, st[0]}, 8'h00);
    rd = st[15:8];
  endtask : dacc

  task automatic latch(input int i, input logic host);
    logic sh;
    logic sn;
    sh = 1'h0;
    sn = 1'h0;
    latch_evt[i] <= 1'h1;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      sh = sh | hirq[i];
      sn = sn | nirq[i];
    end
    @(posedge clk);
    latch_evt[i] <= 1'h0;
    chk("latch irq side", {6'h0, sh, sn}, host ? 8'h02 : 8'h01);
  endtask : latch

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    #100000;
    num_errors++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [7:0] v;
    int         t0;
    int         s0;
    nrst = 1'h0;
    usr_addr = 5'h00;
    usr_wdata = 32'h0;
    usr_wr = 1'h0;
    usr_rd = 1'h0;
    strap = 1'h0;
    latch_evt = 2'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    foreach (ROWS[i])
    begin
      dacc(ROWS[i].ws, ROWS[i].a, ROWS[i].d, 2'h1, v);
      dacc(ROWS[i].rs, ROWS[i].a, 8'h00, 2'h2, v);
      chk("row readback", v, ROWS[i].e);
    end
    $display("register rows done");
    dacc(1'h0, DFL_ADR_TIME_LATCH, 8'h00, 2'h1, v);
    dacc(1'h1, DFL_ADR_TIME_LATCH, 8'h00, 2'h1, v);
    dacc(1'h0, DFL_ADR_LATCH_MODE, 8'h01, 2'h1, v);
    dacc(1'h0, DFL_ADR_TIME_LATCH, 8'h00, 2'h1, v);
    chk("stamp arm count", arm_n[7:0], 8'h01);
    chk("stamp copy count", cpy_n[7:0], 8'h01);
    $display("latch mode test done");
    latch(1, 1'h0);
    dacc(1'h0, DFL_ADR_CYC_OWNER, 8'h20, 2'h1, v);
    latch(1, 1'h1);
    strap <= 1'h1;
    repeat (4) @(posedge clk);
    latch(0, 1'h1);
    dacc(1'h1, DFL_ADR_TDIFF_DEPTH, 8'h05, 2'h1, v);
    dacc(1'h0, DFL_ADR_TDIFF_DEPTH, 8'h02, 2'h1, v);
    dacc(1'h0, DFL_ADR_TDIFF_DEPTH, 8'h00, 2'h2, v);
    chk("host owned depth", v, 8'h05);
    dacc(1'h1, DFL_ADR_CYC_OWNER, 8'h00, 2'h2, v);
    chk("forced latch owner", v, 8'h30);
    $display("ownership test done");
    strap <= 1'h0;
    nrst <= 1'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    dacc(1'h0, DFL_ADR_TDIFF_DEPTH, 8'h00, 2'h2, v);
    chk("difference depth reset", v, 8'h04);
    dacc(1'h1, DFL_ADR_SPEED_DEPTH, 8'h00, 2'h2, v);
    chk("speed depth reset", v, 8'h0C);
    dacc(1'h0, DFL_ADR_CYC_OWNER, 8'h00, 2'h2, v);
    chk("ownership reset", v, 8'h00);
    $display("reset test done");
    // Legacy follow-up: the depth write is chased by two start writes.
    t0 = tclr_n;
    s0 = sclr_n;
    uwr(DFL_CR_CFG, {DFL_START_RST, 15'h0000, 1'h1});
    dacc(1'h0, DFL_ADR_SPEED_DEPTH, 8'h05, 2'h1, v);
    dacc(1'h0, DFL_ADR_SPEED_DEPTH, 8'h00, 2'h2, v);
    chk("legacy speed depth", v, 8'h05);
    chk("legacy speed clears", 8'(sclr_n - s0), 8'h03);
    chk("legacy diff clears", 8'(tclr_n - t0), 8'h02);
    $display("legacy follow-up test done");
    give_verdict();
  end
endmodule : dc_filter_latch_control_test
`default_nettype wire
